// *** rtl/ebtwp_pkg.sv ***
// Purpose: Shared constants and types for the 8-bit timer with prescaler
// Assumes: Byte-wide register port, registers at their printed offsets
// Notes: Control register field positions and reset values live here
`default_nettype none

package ebtwp_pkg;

  // Register offsets
  localparam logic [7:0] PSC_ADDR = 8'hD2;
  localparam logic [7:0] CNT_ADDR = 8'hD3;
  localparam logic [7:0] CTL_ADDR = 8'hD4;

  // Reset values
  localparam logic [6:0] PSC_RESET = 7'h7F;
  localparam logic [7:0] CNT_RESET = 8'hFF;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Status/control field positions
  localparam int FLAG_BIT = 7;
  localparam int IEN_BIT = 6;
  localparam int OSEL_BIT = 5;
  localparam int DOUT_BIT = 4;
  localparam int RUN_BIT = 3;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;

  // Core clock division feeding the prescaler
  localparam int CORE_DIV = 12;

  // Operating modes, in the order of the {output select, data out} code
  typedef enum logic [1:0] {
    MODE_EVENT,
    MODE_GATED,
    MODE_OUT_LOW,
    MODE_OUT_HIGH
  } ebtwp_mode_t;

endpackage

`default_nettype wire

// *** rtl/ebtwp_timer.sv ***
// Purpose: 8-bit downcounter fed by a 7-bit prescaler, with pin modes
// Assumes: Single 50 MHz clock; count pin is asynchronous to it
// Notes: Pin rises are seen after two sync flops, so event rate < clk/3
// Operation
// - Prescaler clocked by core/12 or pin
// - Prescaler reloads 7Fh after reaching zero
// - Counter decrements on each count tick
// - Counter at zero reloads 0FFh next tick
// - Select field picks tap, divide by 2^n
// - Run bit low holds counter, prescaler 7Fh
// - Reset sets counter 0FFh, prescaler 7Fh
// - Prescaler writable while run bit high
// - Counter readable and writable any time
// - Underflow sets flag; enabled flag interrupts
// - Writing 00h or control bit7 sets flag
// - Flag sticky until software clears it
// - Counter write beats coincident underflow
// - Two bits select one of four modes
// - Gated mode counts core/12 while pin high
// - Event mode counts pin rising edges
// - Output mode counts core/12 ignoring pin
// - Flag rise latches data bit onto pin
// - Output select makes pin push-pull output
// - Stop freezes all except event counting
// - Enabled interrupt serves as wake-up
// - Prescaler reads bit 7 as zero
`default_nettype none

module ebtwp_timer #(
  parameter int DIV = ebtwp_pkg::CORE_DIV
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Count pin
  input wire logic i_pin,
  output logic o_pin_out,
  output logic o_pin_oe,
  // Power management
  input wire logic i_stop,
  output logic o_irq,
  output logic o_wakeup
);

  // The divider counter is four bits wide
  if (DIV < 2 || DIV > 15)
  begin
    $error("DIV must lie between 2 and 15");
  end

  localparam logic [3:0] DIV_LAST = 4'(DIV - 1);

  // Tap mask: low n prescaler bits that must be zero for a count tick
  function automatic logic [6:0] tap_mask(input logic [2:0] sel);
    tap_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  logic [6:0] psc;
  logic [7:0] cnt;
  logic flag;
  logic ien;
  logic osel;
  logic dout;
  logic run;
  logic [2:0] sel;
  logic [3:0] div_cnt;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic flag_prev;
  logic out_latch;

  logic psc_wr;
  logic cnt_wr;
  logic ctl_wr;
  logic active;
  logic div_tick;
  logic pin_rise;
  logic ptick;
  logic ctick;
  logic hw_under;
  logic flag_set;
  logic flag_clr;
  ebtwp_pkg::ebtwp_mode_t mode;

  assign psc_wr = i_wr && i_addr == ebtwp_pkg::PSC_ADDR;
  assign cnt_wr = i_wr && i_addr == ebtwp_pkg::CNT_ADDR;
  assign ctl_wr = i_wr && i_addr == ebtwp_pkg::CTL_ADDR;

  assign mode = ebtwp_pkg::ebtwp_mode_t'({osel, dout});

  // Stop freezes counting unless the pin itself clocks the prescaler
  assign active = run && (!i_stop || mode == ebtwp_pkg::MODE_EVENT);

  // Two-flop synchroniser, then edge detect on the synced copy
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else if (i_clk_en)
    begin
      pin_meta <= i_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync && !pin_prev;

  // Core clock divider; held at zero while counting is off
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      div_cnt <= 4'h0;
    end
    else if (i_clk_en)
    begin
      if (!active)
      begin
        div_cnt <= 4'h0;
      end
      else if (div_cnt == DIV_LAST)
      begin
        div_cnt <= 4'h0;
      end
      else
      begin
        div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  assign div_tick = active && div_cnt == DIV_LAST;

  // Prescaler input selection per mode
  always_comb
  begin
    case (mode)
      ebtwp_pkg::MODE_EVENT: ptick = active && pin_rise;
      ebtwp_pkg::MODE_GATED: ptick = div_tick && pin_sync;
      ebtwp_pkg::MODE_OUT_LOW,
      ebtwp_pkg::MODE_OUT_HIGH: ptick = div_tick;
      default: ptick = 1'b0;
    endcase
  end

  // Count tick when the selected low bits wrap through zero
  assign ctick = ptick && !psc_wr && (psc & tap_mask(sel)) == 7'h00;

  // Prescaler
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      psc <= ebtwp_pkg::PSC_RESET;
    end
    else if (i_clk_en)
    begin
      if (!run)
      begin
        psc <= ebtwp_pkg::PSC_RESET;
      end
      else if (psc_wr)
      begin
        psc <= i_wdata[6:0];
      end
      else if (ptick)
      begin
        if (psc == 7'h00)
        begin
          psc <= ebtwp_pkg::PSC_RESET;
        end
        else
        begin
          psc <= psc - 7'h01;
        end
      end
    end
  end

  // Counter: a software write always wins over the tick
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt <= ebtwp_pkg::CNT_RESET;
    end
    else if (i_clk_en)
    begin
      if (cnt_wr)
      begin
        cnt <= i_wdata;
      end
      else if (ctick)
      begin
        if (cnt == 8'h00)
        begin
          cnt <= ebtwp_pkg::CNT_RESET;
        end
        else
        begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end

  assign hw_under = ctick && cnt == 8'h01 && !cnt_wr;
  assign flag_set = hw_under || (cnt_wr && i_wdata == 8'h00)
    || (ctl_wr && i_wdata[ebtwp_pkg::FLAG_BIT]);
  assign flag_clr = ctl_wr && !i_wdata[ebtwp_pkg::FLAG_BIT];

  // Underflow flag; a set in the clearing cycle survives
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flag <= ebtwp_pkg::CTL_RESET[ebtwp_pkg::FLAG_BIT];
    end
    else if (i_clk_en)
    begin
      flag <= flag_set || (flag && !flag_clr);
    end
  end

  // Control bits
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ien <= ebtwp_pkg::CTL_RESET[ebtwp_pkg::IEN_BIT];
      osel <= ebtwp_pkg::CTL_RESET[ebtwp_pkg::OSEL_BIT];
      dout <= ebtwp_pkg::CTL_RESET[ebtwp_pkg::DOUT_BIT];
      run <= ebtwp_pkg::CTL_RESET[ebtwp_pkg::RUN_BIT];
      sel <= ebtwp_pkg::CTL_RESET[ebtwp_pkg::SEL_MSB:ebtwp_pkg::SEL_LSB];
    end
    else if (i_clk_en && ctl_wr)
    begin
      ien <= i_wdata[ebtwp_pkg::IEN_BIT];
      osel <= i_wdata[ebtwp_pkg::OSEL_BIT];
      dout <= i_wdata[ebtwp_pkg::DOUT_BIT];
      run <= i_wdata[ebtwp_pkg::RUN_BIT];
      sel <= i_wdata[ebtwp_pkg::SEL_MSB:ebtwp_pkg::SEL_LSB];
    end
  end

  // Data bit captured only on the flag's rising edge
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flag_prev <= 1'b0;
      out_latch <= 1'b0;
    end
    else if (i_clk_en)
    begin
      flag_prev <= flag;
      if (flag && !flag_prev)
      begin
        out_latch <= dout;
      end
    end
  end

  assign o_pin_out = out_latch;
  assign o_pin_oe = osel;
  assign o_irq = flag && ien;
  assign o_wakeup = flag && ien;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_clk_en)
    begin
      if (i_rd && i_addr == ebtwp_pkg::PSC_ADDR)
      begin
        o_rdata <= {1'b0, psc};
      end
      else if (i_rd && i_addr == ebtwp_pkg::CNT_ADDR)
      begin
        o_rdata <= cnt;
      end
      else if (i_rd && i_addr == ebtwp_pkg::CTL_ADDR)
      begin
        o_rdata <= {flag, ien, osel, dout, run, sel};
      end
      else
      begin
        o_rdata <= 8'h00;
      end
    end
  end

  a_psc_held_idle:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && !run |=> psc == ebtwp_pkg::PSC_RESET && (cnt == $past(cnt) || $past(cnt_wr)))
  else $error("prescaler not held at reload value while stopped");

  a_psc_zero_reload:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && run && ptick && !psc_wr && psc == 7'h00 |=> psc == ebtwp_pkg::PSC_RESET)
  else $error("prescaler did not reload after zero");

  a_cnt_step_down:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && ctick && !cnt_wr && cnt != 8'h00 |=> cnt == $past(cnt) - 8'h01)
  else $error("counter did not step down by one");

  a_cnt_wrap_full:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && ctick && !cnt_wr && cnt == 8'h00 |=> cnt == ebtwp_pkg::CNT_RESET)
  else $error("counter did not reload after zero");

  a_tick_div_one:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    sel == 3'h0 && ptick && !psc_wr |-> ctick)
  else $error("divide-by-one tap missed a tick");

  a_flag_on_under:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && hw_under |=> flag && cnt == 8'h00 ##0 (o_irq == ien))
  else $error("underflow did not raise flag");

  a_flag_sticky:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    flag && !ctl_wr |=> flag)
  else $error("flag cleared without software");

  a_write_wins:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && cnt_wr && i_wdata != 8'h00 && !flag |=> cnt == $past(i_wdata) && !flag)
  else $error("counter write lost or flag set");

  a_pin_latch:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && flag && !flag_prev |=> o_pin_out == $past(dout))
  else $error("pin level not latched on flag rise");

  a_stop_freeze:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_stop && mode != ebtwp_pkg::MODE_EVENT && !i_wr |=> $stable(psc) || !$past(run))
  else $error("prescaler moved during stop");

  a_psc_read_msb:
  assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_clk_en && i_rd && i_addr == ebtwp_pkg::PSC_ADDR
      |=> o_rdata == {1'b0, $past(psc)})
  else $error("prescaler read wrong");

endmodule

`default_nettype wire

// *** test/ebtwp_pin_src.sv ***
// Purpose: Signal source on the timer count pin
// Assumes: Pulses last three clocks high and three low
// Notes: Timer drive wins the wire while its enable is high
`default_nettype none

module ebtwp_pin_src (
  // Clock
  input wire logic i_clk,
  // Timer pin drive
  input wire logic i_out,
  input wire logic i_oe,
  // Wire level
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  assign o_pin = i_oe ? i_out : drv;
  task automatic level(input logic v);
    @(posedge i_clk);
    drv <= v;
  endtask
  // Each level held three clocks so the synchroniser sees it
  task automatic pulses(input int n);
    repeat (n)
    begin
      level(1'b1);
      repeat (2) @(posedge i_clk);
      level(1'b0);
      repeat (2) @(posedge i_clk);
    end
  endtask
endmodule

`default_nettype wire

// *** test/ebtwp_timer_test.sv ***
// Purpose: Self-checking bench for the 8-bit timer with prescaler
// Assumes: Core divider shortened to 2 for run time
// Notes: Clock enable dropped once to check the freeze; no coincident-write case
`default_nettype none

module ebtwp_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic i_stop;
  logic clk_en;
  logic [7:0] o_rdata;
  logic pin;
  logic o_pin_out;
  logic o_pin_oe;
  logic o_irq;
  logic o_wakeup;
  logic [7:0] a;
  logic [7:0] b;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  ebtwp_timer #(.DIV(2)) u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin(pin), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .i_stop(i_stop),
    .o_irq(o_irq), .o_wakeup(o_wakeup));
  ebtwp_pin_src u_src (.i_clk(i_clk), .i_out(o_pin_out), .i_oe(o_pin_oe), .o_pin(pin));

  initial
  begin
    forever #10 i_clk = ~i_clk;
  end

  // Ceiling well above the roughly 750 cycles the sequence needs
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (o_irq !== 1'b1 && k < n)
    begin
      @(posedge i_clk);
      k++;
    end
    repeat (2) @(posedge i_clk);
    #1 chk({6'h0, o_irq, o_wakeup}, 8'h03);
  endtask

  task automatic t_reset_and_flag();
    rd(ebtwp_pkg::PSC_ADDR, a); chk(a, 8'h7F);
    rd(ebtwp_pkg::CNT_ADDR, a); chk(a, 8'hFF);
    rd(ebtwp_pkg::CTL_ADDR, a); chk(a, 8'h00);
    rd(8'hD5, a); chk(a, 8'h00);
    wr(ebtwp_pkg::CTL_ADDR, 8'h80);
    rd(ebtwp_pkg::CTL_ADDR, a); chk(a, 8'h80);
    wr(ebtwp_pkg::CTL_ADDR, 8'h00);
    rd(ebtwp_pkg::CTL_ADDR, a); chk(a, 8'h00);
    wr(ebtwp_pkg::CNT_ADDR, 8'h00);
    rd(ebtwp_pkg::CTL_ADDR, a); chk(a, 8'h80);
    wr(ebtwp_pkg::PSC_ADDR, 8'h05);
    repeat (20) @(posedge i_clk);
    rd(ebtwp_pkg::CNT_ADDR, a); chk(a, 8'h00);
    rd(ebtwp_pkg::PSC_ADDR, a); chk(a, 8'h7F);
  endtask

  // Writes while the enable is low must leave every register alone
  task automatic t_clk_en_freeze();
    @(posedge i_clk);
    clk_en <= 1'b0;
    wr(ebtwp_pkg::CNT_ADDR, 8'h55);
    wr(ebtwp_pkg::CTL_ADDR, 8'h08);
    clk_en <= 1'b1;
    rd(ebtwp_pkg::CNT_ADDR, a); chk(a, 8'h00);
    rd(ebtwp_pkg::CTL_ADDR, a); chk(a, 8'h80);
  endtask

  task automatic t_output();
    wr(ebtwp_pkg::CTL_ADDR, 8'h78);
    wr(ebtwp_pkg::CNT_ADDR, 8'h02);
    wait_irq(60);
    chk({6'h0, o_pin_oe, o_pin_out}, 8'h03);
    rd(ebtwp_pkg::CTL_ADDR, a); chk(a, 8'hF8);
    wr(ebtwp_pkg::CTL_ADDR, 8'h68);
    #1 chk({6'h0, o_irq, o_wakeup}, 8'h00);
    wait_irq(700);
    chk({6'h0, o_pin_oe, o_pin_out}, 8'h02);
    wr(ebtwp_pkg::CTL_ADDR, 8'h28);
    i_stop <= 1'b1;
    rd(ebtwp_pkg::CNT_ADDR, a);
    repeat (20) @(posedge i_clk);
    rd(ebtwp_pkg::CNT_ADDR, b); chk(b, a);
    @(posedge i_clk);
    i_stop <= 1'b0;
  endtask

  task automatic t_event();
    wr(ebtwp_pkg::CTL_ADDR, 8'h08);
    #1 chk({7'h0, o_pin_oe}, 8'h00);
    wr(ebtwp_pkg::CNT_ADDR, 8'h10);
    wr(ebtwp_pkg::PSC_ADDR, 8'h05);
    rd(ebtwp_pkg::PSC_ADDR, a); chk(a, 8'h05);
    u_src.pulses(5);
    rd(ebtwp_pkg::PSC_ADDR, a); chk(a, 8'h00);
    rd(ebtwp_pkg::CNT_ADDR, a); chk(a, 8'h0B);
    u_src.pulses(1);
    rd(ebtwp_pkg::PSC_ADDR, a); chk(a, 8'h7F);
    wr(ebtwp_pkg::CTL_ADDR, 8'h09);
    wr(ebtwp_pkg::CNT_ADDR, 8'h10);
    i_stop <= 1'b1;
    u_src.pulses(4);
    i_stop <= 1'b0;
    rd(ebtwp_pkg::CNT_ADDR, a); chk(a, 8'h0E);
  endtask

  task automatic t_gated();
    // Stop first so the divider phase, and so the tick count, is known
    wr(ebtwp_pkg::CTL_ADDR, 8'h10);
    wr(ebtwp_pkg::CTL_ADDR, 8'h18);
    wr(ebtwp_pkg::PSC_ADDR, 8'h7F);
    repeat (20) @(posedge i_clk);
    rd(ebtwp_pkg::PSC_ADDR, a); chk(a, 8'h7F);
    u_src.level(1'b1);
    repeat (20) @(posedge i_clk);
    rd(ebtwp_pkg::PSC_ADDR, a); chk(a, 8'h75);
    u_src.level(1'b0);
  endtask

  initial
  begin
    i_addr <= 8'h00;
    i_wdata <= 8'h00;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    i_stop <= 1'b0;
    clk_en <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_reset_and_flag();
    t_clk_en_freeze();
    t_output();
    t_event();
    t_gated();
    final_report();
  end
endmodule

`default_nettype wire
